// ===== expbus_cycle_ctrl.sv
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module expbus_cycle_ctrl
    import expbus_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic cyc_req,
    input wire logic [19:0] cyc_addr,
    input wire logic cyc_mem,
    input wire logic cyc_write,
    input wire logic cyc_rom,
    input wire logic pcs0_hit,
    input wire logic pcs2_hit,
    output logic cyc_busy,
    output logic cyc_done,
    input wire logic exp_clk_src,
    input wire logic iocs16_n,
    input wire logic memcs16_n,
    output logic sysclk,
    output logic iord_n,
    output logic iowr_n,
    output logic memr_n,
    output logic memw_n,
    output logic smrd_n,
    output logic alt_cs_n,
    output logic bus16,
    output logic activity_retrigger
);

    logic [7:0] alt_select_mode, alt_select_range_low, alt_select_range_end;
    logic [7:0] alt_select_upper_compare, expansion_bus_mode, io_wait_control;
    logic [7:0] memory_wait_control, ap_idx;
    logic ap_valid, ap_write, rd_pend;

    // Field views of the registers
    logic mem_io_select, data_width_sel, activity_monitor_en, rom_read_strobe_block;
    logic [1:0] and_target_sel, strobe_qualify_mode, bus_clock_policy, leadoff_delay_sel;
    logic [2:0] io_wait_count, narrow_mem_wait_count, wide_mem_wait_count;
    assign mem_io_select = alt_select_mode[POS_MEM_IO];
    assign data_width_sel = alt_select_mode[POS_WIDTH];
    assign activity_monitor_en = alt_select_mode[POS_MONITOR];
    assign and_target_sel = alt_select_mode[POS_TARGET+:2];
    assign strobe_qualify_mode = alt_select_mode[POS_QUAL+:2];
    assign bus_clock_policy = expansion_bus_mode[POS_CLK_POLICY+:2];
    assign leadoff_delay_sel = expansion_bus_mode[POS_LEADOFF+:2];
    assign rom_read_strobe_block = expansion_bus_mode[POS_ROM_BLOCK];
    assign io_wait_count = io_wait_control[POS_IO_WAIT+:3];
    assign narrow_mem_wait_count = memory_wait_control[POS_NARROW_WAIT+:3];
    assign wide_mem_wait_count = memory_wait_control[POS_WIDE_WAIT+:3];

    // Shared map decode for the read and write paths
    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = (idx == IDX_ALT_MODE) || (idx == IDX_ALT_LOW) ||
                    (idx == IDX_ALT_END) || (idx == IDX_ALT_UPPER) ||
                    (idx == IDX_BUS_MODE) || (idx == IDX_IO_WAIT) ||
                    (idx == IDX_MEM_WAIT);
    endfunction

    function automatic logic [7:0] read_reg(input logic [7:0] idx);
        logic [7:0] val;
        val = 8'h00;
        if (is_mapped(idx)) begin
            case (idx)
                IDX_ALT_MODE: val = alt_select_mode;
                IDX_ALT_LOW: val = alt_select_range_low;
                IDX_ALT_END: val = alt_select_range_end;
                IDX_ALT_UPPER: val = alt_select_upper_compare;
                IDX_BUS_MODE: val = expansion_bus_mode;
                IDX_IO_WAIT: val = io_wait_control;
                default: val = memory_wait_control;
            endcase
        end
        read_reg = val;
    endfunction

    // Address phase capture; addresses at 0x400 and above fold onto unmapped index 0
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_idx <= 8'h00;
        end else if (hready) begin
            ap_valid <= hsel && htrans[1];
            ap_write <= hwrite;
            ap_idx <= (haddr[31:10] == 22'h00_0000) ? haddr[9:2] : 8'h00;
        end
    end

    // Reads take one wait state so a write just before is always seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            rd_pend <= 1'b0;
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
            rd_pend <= 1'b0;
            if (rd_pend) begin
                hrdata <= {24'h00_0000, read_reg(ap_idx)};
                hreadyout <= 1'b1;
            end else if (hready && hsel && htrans[1] && !hwrite) begin
                hreadyout <= 1'b0;
                rd_pend <= 1'b1;
            end
        end
    end

    // Register writes in the data phase; unmapped writes are dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alt_select_mode <= RST_ALT_MODE;
            alt_select_range_low <= RST_RANGE;
            alt_select_range_end <= RST_RANGE;
            alt_select_upper_compare <= RST_RANGE;
            expansion_bus_mode <= RST_BUS_MODE;
            io_wait_control <= RST_IO_WAIT;
            memory_wait_control <= RST_MEM_WAIT;
        end else if (ap_valid && ap_write && hready && is_mapped(ap_idx)) begin
            case (ap_idx)
                IDX_ALT_MODE: alt_select_mode <= hwdata[7:0] & MASK_ALT_MODE;
                IDX_ALT_LOW: alt_select_range_low <= hwdata[7:0];
                IDX_ALT_END: alt_select_range_end <= hwdata[7:0];
                IDX_ALT_UPPER: alt_select_upper_compare <= hwdata[7:0];
                IDX_BUS_MODE: expansion_bus_mode <= hwdata[7:0] & MASK_BUS_MODE;
                IDX_IO_WAIT: io_wait_control <= hwdata[7:0] & MASK_IO_WAIT;
                default: memory_wait_control <= hwdata[7:0] & MASK_MEM_WAIT;
            endcase
        end
    end

    // Pin synchronisers; the second stage feeds logic, and a third clock stage feeds the edge detect
    logic clk_s1, clk_s2, clk_s3;
    logic io16_s1, io16_s2, mem16_s1, mem16_s2, tick;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_s1 <= 1'b0;
            clk_s2 <= 1'b0;
            clk_s3 <= 1'b0;
            io16_s1 <= 1'b1;
            io16_s2 <= 1'b1;
            mem16_s1 <= 1'b1;
            mem16_s2 <= 1'b1;
        end else begin
            clk_s1 <= exp_clk_src;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
            io16_s1 <= iocs16_n;
            io16_s2 <= io16_s1;
            mem16_s1 <= memcs16_n;
            mem16_s2 <= mem16_s1;
        end
    end
    // Each source edge is one half period of the expansion clock
    assign tick = clk_s2 ^ clk_s3;

    // Window decode; both bounds inclusive
    logic [7:0] cmp_byte;
    logic upper_eq, in_range, sel_type_ok, and_ok, req_hit;
    assign cmp_byte = cyc_mem ? cyc_addr[15:8] : cyc_addr[7:0];
    assign upper_eq = cyc_mem ? (cyc_addr[19:16] == alt_select_upper_compare[3:0])
                              : (cyc_addr[15:8] == alt_select_upper_compare);
    assign in_range = (cmp_byte >= alt_select_range_low) &&
                      (cmp_byte <= alt_select_range_end) && upper_eq;
    assign sel_type_ok = (cyc_mem == mem_io_select);
    // Reserved target code behaves as no AND term
    assign and_ok = (and_target_sel == TGT_FIRST) ? pcs0_hit :
                    (and_target_sel == TGT_THIRD) ? pcs2_hit : 1'b1;
    assign req_hit = in_range && sel_type_ok && and_ok &&
                     (strobe_qualify_mode != QUAL_OFF);

    // Cycle engine state
    cyc_state_t state;
    logic [1:0] lead_cnt;
    logic [4:0] half_cnt;
    logic cur_mem, cur_write, cur_rom, cur_hit, accept, align_go, cmd_end, in_cmd_next;
    assign accept = cyc_req && (state == ST_IDLE);

    // Alignment to the expansion clock according to the policy
    always_comb begin
        case (bus_clock_policy)
            CLK_SYNC: align_go = tick && !sysclk;
            CLK_STRETCH: align_go = !sysclk;
            default: align_go = 1'b1;
        endcase
    end

    // Sequencer: lead-off in processor clocks, then command in half periods
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_IDLE;
            lead_cnt <= 2'h0;
            half_cnt <= 5'h00;
            cur_mem <= 1'b0;
            cur_write <= 1'b0;
            cur_rom <= 1'b0;
            cur_hit <= 1'b0;
            bus16 <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (accept) begin
                        cur_mem <= cyc_mem;
                        cur_write <= cyc_write;
                        cur_rom <= cyc_rom;
                        cur_hit <= req_hit;
                        lead_cnt <= leadoff_delay_sel;
                        state <= (leadoff_delay_sel == 2'h0) ? ST_ALIGN : ST_LEAD;
                    end
                end
                ST_LEAD: begin
                    lead_cnt <= lead_cnt - 2'h1;
                    if (lead_cnt == 2'h1) begin
                        state <= ST_ALIGN;
                    end
                end
                ST_ALIGN: begin
                    if (align_go) begin
                        state <= ST_CMD;
                        // Forced width ignores the device's request pins
                        bus16 <= (cur_hit && data_width_sel) ||
                                 (cur_mem ? !mem16_s2 : !io16_s2);
                        if (!cur_mem) begin
                            half_cnt <= HALF_NARROW_ZERO_WAIT + {1'b0, io_wait_count, 1'b0};
                        end else if ((cur_hit && data_width_sel) || !mem16_s2) begin
                            half_cnt <= HALF_WIDE_ZERO_WAIT + {1'b0, wide_mem_wait_count, 1'b0};
                        end else begin
                            half_cnt <= HALF_NARROW_ZERO_WAIT + {1'b0, narrow_mem_wait_count, 1'b0};
                        end
                    end
                end
                ST_CMD: begin
                    if (tick) begin
                        half_cnt <= half_cnt - 5'h01;
                        if (half_cnt == 5'h01) begin
                            state <= ST_IDLE;
                            bus16 <= 1'b0;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    assign cmd_end = (state == ST_CMD) && tick && (half_cnt == 5'h01);

    // Expansion clock; stop policy parks it low between cycles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sysclk <= 1'b0;
        end else begin
            case (bus_clock_policy)
                CLK_SYNC: begin
                    if (tick) begin
                        sysclk <= !sysclk;
                    end
                end
                CLK_STRETCH: begin
                    // Low phase is cut to the cycle start so the first rise opens it
                    if (state == ST_ALIGN && !sysclk) begin
                        sysclk <= 1'b1;
                    end else if (tick) begin
                        sysclk <= !sysclk;
                    end
                end
                default: begin
                    if (tick && ((state == ST_CMD && !cmd_end) || sysclk)) begin
                        sysclk <= !sysclk;
                    end
                end
            endcase
        end
    end

    // Command strobes, ROM read strobe and the alternate select
    assign in_cmd_next = (state == ST_ALIGN && align_go) || (state == ST_CMD && !cmd_end);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            iord_n <= 1'b1;
            iowr_n <= 1'b1;
            memr_n <= 1'b1;
            memw_n <= 1'b1;
            smrd_n <= 1'b1;
            alt_cs_n <= 1'b1;
        end else begin
            iord_n <= !(in_cmd_next && !cur_mem && !cur_write);
            iowr_n <= !(in_cmd_next && !cur_mem && cur_write);
            memr_n <= !(in_cmd_next && cur_mem && !cur_write);
            memw_n <= !(in_cmd_next && cur_mem && cur_write);
            smrd_n <= !(in_cmd_next && cur_mem && !cur_write &&
                        !(cur_rom && rom_read_strobe_block));
            case (strobe_qualify_mode)
                QUAL_READ: alt_cs_n <= !(cur_hit && in_cmd_next && !cur_write);
                QUAL_WRITE: alt_cs_n <= !(cur_hit && in_cmd_next && cur_write);
                QUAL_DECODE: alt_cs_n <= !(cur_hit && (state != ST_IDLE) && !cmd_end);
                default: alt_cs_n <= 1'b1;
            endcase
        end
    end

    // Handshake to the requester and the activity pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cyc_busy <= 1'b0;
            cyc_done <= 1'b0;
            activity_retrigger <= 1'b0;
        end else begin
            cyc_busy <= accept || ((state != ST_IDLE) && !cmd_end);
            cyc_done <= cmd_end;
            activity_retrigger <= accept && req_hit && activity_monitor_en;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_leadoff_two: assert property (
        (accept && leadoff_delay_sel == 2'h2) |=>
            state == ST_LEAD ##1 state == ST_LEAD ##1 state == ST_ALIGN)
        else $error("lead-off of two clocks not kept");
    a_stop_parked: assert property (
        (bus_clock_policy == CLK_STOP && state == ST_IDLE && !sysclk &&
         !accept && $stable(bus_clock_policy)) |=> !sysclk)
        else $error("expansion clock ran while idle in stop policy");
    a_sync_start: assert property (
        (bus_clock_policy == CLK_SYNC && state == ST_ALIGN ##1 state == ST_CMD)
            |-> $rose(sysclk))
        else $error("sync cycle did not start on a clock rise");
    a_io_width: assert property (
        ($rose(state == ST_CMD) && !cur_mem) |->
            half_cnt == 5'(3 + 2 * $past(io_wait_count)))
        else $error("I/O command length wrong");
    a_narrow_width: assert property (
        ($rose(state == ST_CMD) && cur_mem && !bus16) |->
            half_cnt == 5'(3 + 2 * $past(narrow_mem_wait_count)))
        else $error("narrow memory command length wrong");
    a_wide_width: assert property (
        ($rose(state == ST_CMD) && cur_mem && bus16) |->
            half_cnt == 5'(4 + 2 * $past(wide_mem_wait_count)))
        else $error("wide memory command length wrong");
    a_strobe_ends: assert property (
        cmd_end |=> (iord_n && iowr_n && memr_n && memw_n && state == ST_IDLE))
        else $error("command strobe outlived its count");
    a_alt_off: assert property (
        (strobe_qualify_mode == QUAL_OFF) [*2] |-> alt_cs_n)
        else $error("alternate select asserted while disabled");
    a_rom_block: assert property (
        !smrd_n |-> !($past(rom_read_strobe_block) && cur_rom))
        else $error("ROM read strobe not inhibited");
    a_retrigger_gate: assert property (
        activity_retrigger |-> $past(activity_monitor_en && req_hit))
        else $error("activity retrigger without monitor enable");
    a_forced_wide: assert property (
        ($rose(state == ST_CMD) && cur_hit && $past(data_width_sel)) |-> bus16)
        else $error("forced 16-bit width not applied");
    a_io_decode: assert property (
        (accept && !cyc_mem && cyc_addr[15:8] != alt_select_upper_compare) |=> !cur_hit)
        else $error("I/O upper byte mismatch still hit");

    c_stop_io: cover property (bus_clock_policy == CLK_STOP && !iord_n);
    c_sync_mem: cover property (bus_clock_policy == CLK_SYNC && !memr_n);
    c_stretch: cover property (bus_clock_policy == CLK_STRETCH && cmd_end);
    c_alt_hit: cover property (!alt_cs_n && !memw_n);

endmodule

`default_nettype wire

// ===== expbus_pkg.sv
package expbus_pkg;

    // Register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_ALT_MODE = 8'h2c;
    localparam logic [7:0] IDX_ALT_LOW = 8'h2d;
    localparam logic [7:0] IDX_ALT_END = 8'h2e;
    localparam logic [7:0] IDX_ALT_UPPER = 8'h2f;
    localparam logic [7:0] IDX_BUS_MODE = 8'h34;
    localparam logic [7:0] IDX_IO_WAIT = 8'h35;
    localparam logic [7:0] IDX_MEM_WAIT = 8'h36;

    // Reset values
    localparam logic [7:0] RST_ALT_MODE = 8'h0c;
    localparam logic [7:0] RST_RANGE = 8'h00;
    localparam logic [7:0] RST_BUS_MODE = 8'h00;
    localparam logic [7:0] RST_IO_WAIT = 8'h40;
    localparam logic [7:0] RST_MEM_WAIT = 8'h44;

    // Writable bits; reserved bits stay zero
    localparam logic [7:0] MASK_ALT_MODE = 8'hbf;
    localparam logic [7:0] MASK_BUS_MODE = 8'hf8;
    localparam logic [7:0] MASK_IO_WAIT = 8'h70;
    localparam logic [7:0] MASK_MEM_WAIT = 8'h77;

    // Field positions
    localparam int POS_MEM_IO = 7;
    localparam int POS_WIDTH = 5;
    localparam int POS_MONITOR = 4;
    localparam int POS_TARGET = 2;
    localparam int POS_QUAL = 0;
    localparam int POS_CLK_POLICY = 6;
    localparam int POS_LEADOFF = 4;
    localparam int POS_ROM_BLOCK = 3;
    localparam int POS_IO_WAIT = 4;
    localparam int POS_NARROW_WAIT = 4;
    localparam int POS_WIDE_WAIT = 0;

    // Field codes
    localparam logic [1:0] CLK_STOP = 2'h0;
    localparam logic [1:0] CLK_SYNC = 2'h1;
    localparam logic [1:0] CLK_STRETCH = 2'h2;
    localparam logic [1:0] TGT_FIRST = 2'h0;
    localparam logic [1:0] TGT_THIRD = 2'h2;
    localparam logic [1:0] QUAL_OFF = 2'h0;
    localparam logic [1:0] QUAL_READ = 2'h1;
    localparam logic [1:0] QUAL_WRITE = 2'h2;
    localparam logic [1:0] QUAL_DECODE = 2'h3;

    // Command widths in expansion clock half periods
    localparam logic [4:0] HALF_NARROW_ZERO_WAIT = 5'h3;
    localparam logic [4:0] HALF_WIDE_ZERO_WAIT = 5'h4;

    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_ALIGN, ST_CMD} cyc_state_t;

endpackage

// ===== exp_dev_model.sv
`timescale 1ns/1ps
`default_nettype none

// Far-side peripheral that asks for 16-bit transfers on demand
module exp_dev_model (
    input wire logic mem,
    input wire logic want16,
    output logic iocs16_n,
    output logic memcs16_n
);
    // Pins driven directly: released lines read high, never a stale low
    assign iocs16_n = ~(want16 & ~mem);
    assign memcs16_n = ~(want16 & mem);
endmodule

`default_nettype wire

// ===== tb_expansion_bus_cycle_and_alt_chip_select.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end

module tb_expansion_bus_cycle_and_alt_chip_select;
    import expbus_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, cyc_req, cyc_mem;
    logic cyc_write, cyc_rom, pcs0_hit, pcs2_hit, cyc_busy, cyc_done, exp_clk_src;
    logic iocs16_n, memcs16_n, sysclk, iord_n, iowr_n, memr_n, memw_n, smrd_n;
    logic alt_cs_n, bus16, activity_retrigger, want16, lv;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [19:0] cyc_addr;
    logic [7:0] sh [0:255];
    int err_total, checked, cyc_cnt, t;
    logic [7:0] regs [8] = '{8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h34, 8'h35, 8'h36, 8'h30};
    logic [7:0] bms [4] = '{8'h00, 8'h78, 8'h98, 8'h30};
    logic [19:0] ioa [4] = '{20'h0_0310, 20'h0_0320, 20'h0_0321, 20'h0_0410};
    logic [19:0] mema [4] = '{20'h5_1000, 20'h5_20ff, 20'h5_2100, 20'h5_1010};

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;
    expbus_cycle_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cyc_req(cyc_req),
        .cyc_addr(cyc_addr), .cyc_mem(cyc_mem), .cyc_write(cyc_write), .cyc_rom(cyc_rom),
        .pcs0_hit(pcs0_hit), .pcs2_hit(pcs2_hit), .cyc_busy(cyc_busy), .cyc_done(cyc_done),
        .exp_clk_src(exp_clk_src), .iocs16_n(iocs16_n), .memcs16_n(memcs16_n),
        .sysclk(sysclk), .iord_n(iord_n), .iowr_n(iowr_n), .memr_n(memr_n),
        .memw_n(memw_n), .smrd_n(smrd_n), .alt_cs_n(alt_cs_n), .bus16(bus16),
        .activity_retrigger(activity_retrigger));
    exp_dev_model dev (.mem(cyc_mem), .want16(want16), .iocs16_n(iocs16_n),
        .memcs16_n(memcs16_n));

    initial begin
        hclk = 0;
        forever #20 hclk = ~hclk;
    end
    // Source clock phase offset keeps it unrelated to hclk
    initial begin
        exp_clk_src = 0;
        #7;
        forever #160 exp_clk_src = ~exp_clk_src;
    end

    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Hang guard, well above the few thousand cycles the run needs
    always @(posedge hclk) begin
        cyc_cnt++;
        if (cyc_cnt == 40000) begin
            err_total++;
            summarize();
        end
    end

    function automatic logic [7:0] msk(input logic [7:0] i);
        case (i)
            8'h2c: return 8'hbf;
            8'h2d, 8'h2e, 8'h2f: return 8'hff;
            8'h34: return 8'hf8;
            8'h35: return 8'h70;
            8'h36: return 8'h77;
            default: return 8'h00;
        endcase
    endfunction

    // One AHB single transfer; called just after a rising edge
    task automatic ahb(input logic w, input logic [7:0] i, input logic [7:0] d);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= {22'h0, i, 2'h0};
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 0;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        r = hrdata;
        `CHK(hresp, 1'b0)
        if (w) sh[i] = d & msk(i);
        else `CHK(r, {24'h0, sh[i]})
    endtask

    // Run one expansion cycle and compare its shape with the model
    task automatic cyc(input logic [19:0] a, input logic mem, wr, rom, w16);
        int n, f, it, cs, b, sm, rt, h, ecs, eb, tk;
        logic p0, p2;
        logic [7:0] m, s, st;
        p0 = 1'($urandom);
        p2 = 1'($urandom);
        cyc_addr <= a;
        cyc_mem <= mem;
        cyc_write <= wr;
        cyc_rom <= rom;
        want16 <= w16;
        pcs0_hit <= p0;
        pcs2_hit <= p2;
        repeat (4) @(posedge hclk);
        cyc_req <= 1;
        {n, f, it, cs, b, sm, rt} = 0;
        do begin
            @(posedge hclk);
            it++;
            if (cyc_busy === 1'b1) cyc_req <= 0;
            st = mem ? (wr ? memw_n : memr_n) : (wr ? iowr_n : iord_n);
            if (st[0] === 1'b0) n++;
            if (st[0] === 1'b0 && f == 0) f = it;
            cs |= (alt_cs_n === 1'b0);
            b |= (bus16 === 1'b1);
            sm |= (smrd_n === 1'b0);
            rt |= (activity_retrigger === 1'b1);
        end while (cyc_done !== 1'b1 && it < 600);
        `CHK(it < 600, 1'b1)
        m = sh[8'h2c];
        s = mem ? a[15:8] : a[7:0];
        h = (m[1:0] != 0) && (m[7] == mem) && s >= sh[8'h2d] && s <= sh[8'h2e];
        h = h && (mem ? a[19:16] == sh[8'h2f][3:0] : a[15:8] == sh[8'h2f]);
        if (m[3:2] == 2'h0) h = h && p0;
        if (m[3:2] == 2'h2) h = h && p2;
        ecs = h && (m[1:0] == 3 || m[1:0] == (wr ? 2 : 1));
        eb = (h && m[5]) || w16;
        tk = !mem ? 3 + 2 * sh[8'h35][6:4] : eb ? 4 + 2 * sh[8'h36][2:0]
            : 3 + 2 * sh[8'h36][6:4];
        `CHK(cs, ecs)
        `CHK(rt, h && m[4])
        `CHK(b, eb)
        `CHK((n + 3) / 4, tk)
        `CHK(sm, mem && !wr && !(rom && sh[8'h34][3]))
        if (sh[8'h34][7:6] == 0) `CHK(f, 3 + sh[8'h34][5:4])
        // Peripheral lets its 16-bit request go once its cycle is over
        want16 <= 1'b0;
        @(posedge hclk);
    endtask

    initial begin
        {hresetn, hsel, hwrite, cyc_req, cyc_mem, cyc_write, cyc_rom} = 0;
        {pcs0_hit, pcs2_hit, want16, htrans, haddr, hwdata, cyc_addr} = 0;
        hsize = 3'h2;
        {err_total, checked, cyc_cnt} = 0;
        foreach (sh[i]) sh[i] = 8'h00;
        sh[8'h2c] = 8'h0c;
        sh[8'h35] = 8'h40;
        sh[8'h36] = 8'h44;
        void'($urandom(32'h857a5512));
        repeat (3) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        // Reset values, then reserved bits dropped and unmapped word reads zero
        foreach (regs[i]) ahb(0, regs[i], 8'h00);
        foreach (regs[i]) ahb(1, regs[i], 8'hff);
        foreach (regs[i]) ahb(0, regs[i], 8'h00);
        ahb(1, 8'h2d, 8'h10);
        ahb(1, 8'h2e, 8'h20);
        foreach (bms[k]) begin
            ahb(1, 8'h34, bms[k]);
            ahb(1, 8'h35, 8'($urandom));
            ahb(1, 8'h36, 8'($urandom));
            // Idle clock must be still only in stop policy; a parked clock may need a tick
            repeat (8) @(posedge hclk);
            t = 0;
            lv = sysclk;
            repeat (24) begin
                @(posedge hclk);
                if (sysclk !== lv) t++;
                lv = sysclk;
            end
            `CHK(t != 0, bms[k][7:6] != 0)
            ahb(1, 8'h2f, 8'h03);
            ahb(1, 8'h2c, 8'h0c | (8'($urandom) & 8'h33));
            foreach (ioa[j]) cyc(ioa[j], 0, 1'($urandom), 0, 1'($urandom));
            ahb(1, 8'h2f, 8'hf5);
            ahb(1, 8'h2c, 8'h80 | (8'($urandom) & 8'h3b));
            foreach (mema[j]) cyc(mema[j], j != 3, 1'($urandom), 1'($urandom), 1'($urandom));
        end
        summarize();
    end
endmodule

`default_nettype wire
